/* File: rtl/bsc_defs.vh */
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH
// ------------------------------------------------------------
// chain and instruction constants
// ------------------------------------------------------------
`define BSC_CHAIN_LEN   109
`define BSC_IR_W        3
`define BSC_IR_EXTEST   3'h0
`define BSC_IR_IDCODE   3'h1
`define BSC_IR_SAMPZ    3'h2
`define BSC_IR_SAMPLE   3'h4
`define BSC_IR_BYPASS   3'h7
`define BSC_ID_W        32
`define BSC_ID_VALUE    32'h0000_0001
`define BSC_TLR_EDGES   5
// ------------------------------------------------------------
// state codes of the test-port state machine
// ------------------------------------------------------------
`define BSC_S_TLR   4'h0
`define BSC_S_RTI   4'h1
`define BSC_S_SDR   4'h2
`define BSC_S_CDR   4'h3
`define BSC_S_SHDR  4'h4
`define BSC_S_E1DR  4'h5
`define BSC_S_PDR   4'h6
`define BSC_S_E2DR  4'h7
`define BSC_S_UDR   4'h8
`define BSC_S_SIR   4'h9
`define BSC_S_CIR   4'ha
`define BSC_S_SHIR  4'hb
`define BSC_S_E1IR  4'hc
`define BSC_S_PIR   4'hd
`define BSC_S_E2IR  4'he
`define BSC_S_UIR   4'hf
`endif

/* File: rtl/bsc_pin_sync.v */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change counts once stages two and three agree
module bsc_pin_sync (
  input  wire clock,
  input  wire rst,
  input  wire pin,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ------------------------------------------------------------
  // sampling chain
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;  // filtered level
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/bsc_scan_chain.v */
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defs.vh"
module bsc_scan_chain (
  input  wire         clock,
  input  wire         rst,
  input  wire         test_clk,
  input  wire         mode_sel,
  input  wire         scan_in,
  input  wire [108:1] ball_in,
  input  wire         clk_in_true,
  input  wire         clk_in_inv,
  input  wire         clk_out_true,
  input  wire         clk_out_inv,
  output reg          scan_out,
  output reg          scan_out_oe,
  output reg  [108:1] ball_drive,
  output reg          ball_drive_en,
  output reg          outputs_float,
  output reg          echo_out_true,
  output reg          echo_out_inv,
  output wire [2:0]   instr,
  output wire [3:0]   tap_state
);
  wire         tck_lvl;
  wire         tms_lvl;
  wire         tdi_lvl;
  wire         ci_t;
  wire         ci_i;
  wire         co_t;
  wire         co_i;
  reg          tck_prev_q;
  reg  [3:0]   state_q;
  reg  [3:0]   state_d;
  reg  [2:0]   ir_q;
  reg  [2:0]   ir_sh_q;
  reg  [`BSC_CHAIN_LEN:1] bs_q;
  reg  [`BSC_ID_W-1:0]    id_q;
  reg          bp_q;
  reg  [2:0]   hi_cnt_q;
  wire [114:0] pin_raw;
  wire [114:0] pin_lvl;
  wire [108:1] ball_lvl;
  genvar       g;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // every pin is foreign to the system clock, the balls included
  // balls reach the chain four clocks late; a capture needs them steady anyway
  assign pin_raw = {ball_in, clk_out_inv, clk_out_true, clk_in_inv, clk_in_true,
                    scan_in, mode_sel, test_clk};
  generate
    for (g = 0; g < 115; g = g + 1) begin : g_sync
      bsc_pin_sync i_sync (
        .clock   (clock),
        .rst     (rst),
        .pin     (pin_raw[g]),
        .level_q (pin_lvl[g])
      );
    end
  endgenerate

  // filtered levels under their working names
  assign tck_lvl  = pin_lvl[0];
  assign tms_lvl  = pin_lvl[1];
  assign tdi_lvl  = pin_lvl[2];
  assign ci_t     = pin_lvl[3];
  assign ci_i     = pin_lvl[4];
  assign co_t     = pin_lvl[5];
  assign co_i     = pin_lvl[6];
  assign ball_lvl = pin_lvl[114:7];

  wire tck_rise = tck_lvl & ~tck_prev_q;
  wire tck_fall = ~tck_lvl & tck_prev_q;

  // five high edges in a row force the reset state
  wire       force_tlr = tms_lvl && (hi_cnt_q == (`BSC_TLR_EDGES - 1));
  wire [3:0] state_nx  = force_tlr ? `BSC_S_TLR : state_d;

  assign instr     = ir_q;
  assign tap_state = state_q;

  // selects the chain behind the data path for the loaded instruction
  function sel_bs;
    input [2:0] ir;
    begin
      sel_bs = (ir == `BSC_IR_EXTEST) || (ir == `BSC_IR_SAMPZ) || (ir == `BSC_IR_SAMPLE);
    end
  endfunction

  // ------------------------------------------------------------
  // next state from mode-select
  // ------------------------------------------------------------
  always @* begin
    case (state_q)
      `BSC_S_TLR:  state_d = tms_lvl ? `BSC_S_TLR  : `BSC_S_RTI;
      `BSC_S_RTI:  state_d = tms_lvl ? `BSC_S_SDR  : `BSC_S_RTI;
      `BSC_S_SDR:  state_d = tms_lvl ? `BSC_S_SIR  : `BSC_S_CDR;
      `BSC_S_CDR:  state_d = tms_lvl ? `BSC_S_E1DR : `BSC_S_SHDR;
      `BSC_S_SHDR: state_d = tms_lvl ? `BSC_S_E1DR : `BSC_S_SHDR;
      `BSC_S_E1DR: state_d = tms_lvl ? `BSC_S_UDR  : `BSC_S_PDR;
      `BSC_S_PDR:  state_d = tms_lvl ? `BSC_S_E2DR : `BSC_S_PDR;
      `BSC_S_E2DR: state_d = tms_lvl ? `BSC_S_UDR  : `BSC_S_SHDR;
      `BSC_S_UDR:  state_d = tms_lvl ? `BSC_S_SDR  : `BSC_S_RTI;
      `BSC_S_SIR:  state_d = tms_lvl ? `BSC_S_TLR  : `BSC_S_CIR;
      `BSC_S_CIR:  state_d = tms_lvl ? `BSC_S_E1IR : `BSC_S_SHIR;
      `BSC_S_SHIR: state_d = tms_lvl ? `BSC_S_E1IR : `BSC_S_SHIR;
      `BSC_S_E1IR: state_d = tms_lvl ? `BSC_S_UIR  : `BSC_S_PIR;
      `BSC_S_PIR:  state_d = tms_lvl ? `BSC_S_E2IR : `BSC_S_PIR;
      `BSC_S_E2IR: state_d = tms_lvl ? `BSC_S_UIR  : `BSC_S_SHIR;
      `BSC_S_UIR:  state_d = tms_lvl ? `BSC_S_SDR  : `BSC_S_RTI;
      default:     state_d = `BSC_S_TLR;
    endcase
  end

  // ------------------------------------------------------------
  // controller and data registers, stepped on test clock rise
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tck_prev_q <= 1'b0;
      state_q    <= `BSC_S_TLR;
      ir_q       <= `BSC_IR_IDCODE;  // power-up instruction
      ir_sh_q    <= 3'h0;
      bs_q       <= {`BSC_CHAIN_LEN{1'b0}};
      id_q       <= `BSC_ID_VALUE;
      bp_q       <= 1'b0;
      hi_cnt_q   <= 3'h0;
    end else begin
      tck_prev_q <= tck_lvl;
      if (tck_rise) begin
        // the explicit count backs up the graph's own path to reset
        if (force_tlr) begin
          state_q  <= `BSC_S_TLR;
          hi_cnt_q <= 3'h0;
        end else begin
          state_q  <= state_d;
          hi_cnt_q <= tms_lvl ? hi_cnt_q + 3'h1 : 3'h0;
        end
        case (state_q)
          `BSC_S_TLR: ir_q <= `BSC_IR_IDCODE;
          `BSC_S_CIR: ir_sh_q <= 3'h1;
          `BSC_S_SHIR: ir_sh_q <= {tdi_lvl, ir_sh_q[2:1]};
          `BSC_S_UIR: ir_q <= ir_sh_q;
          `BSC_S_CDR: begin
            id_q <= `BSC_ID_VALUE;
            bp_q <= 1'b0;
            // cell 109 captures a fixed internal level
            if (sel_bs(ir_q)) bs_q <= {1'b1, ball_lvl};
          end
          `BSC_S_SHDR: begin
            if (sel_bs(ir_q)) bs_q <= {tdi_lvl, bs_q[`BSC_CHAIN_LEN:2]};
            else if (ir_q == `BSC_IR_IDCODE) id_q <= {tdi_lvl, id_q[`BSC_ID_W-1:1]};
            else bp_q <= tdi_lvl;
          end
          default: ;
        endcase
        // either path into the reset state reloads identification at once
        if (state_nx == `BSC_S_TLR) ir_q <= `BSC_IR_IDCODE;
      end
    end
  end

  // ------------------------------------------------------------
  // serial output and ball drive
  // ------------------------------------------------------------
  // output changes on the falling test clock edge as the port expects
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      scan_out      <= 1'b0;
      scan_out_oe   <= 1'b0;
      ball_drive    <= {108{1'b0}};
      ball_drive_en <= 1'b0;
      outputs_float <= 1'b0;
    end else begin
      if (tck_fall) begin
        scan_out_oe <= (state_q == `BSC_S_SHDR) || (state_q == `BSC_S_SHIR);
        if (state_q == `BSC_S_SHIR) scan_out <= ir_sh_q[0];
        else if (sel_bs(ir_q)) scan_out <= bs_q[1];
        else if (ir_q == `BSC_IR_IDCODE) scan_out <= id_q[0];
        else scan_out <= bp_q;
        if (state_q == `BSC_S_UDR) ball_drive <= bs_q[108:1];
      end
      ball_drive_en <= (ir_q == `BSC_IR_EXTEST);
      outputs_float <= (ir_q == `BSC_IR_SAMPZ);
    end
  end

  // ------------------------------------------------------------
  // echo clocks
  // ------------------------------------------------------------
  // echo outputs hold their level under extest and float; keeping the
  // clock pairs at opposite levels is left to the board controller
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      echo_out_true <= 1'b0;
      echo_out_inv  <= 1'b0;
    end else if (ir_q != `BSC_IR_EXTEST && ir_q != `BSC_IR_SAMPZ) begin
      if (co_t && co_i) begin
        echo_out_true <= ci_t;
        echo_out_inv  <= ci_i;
      end else begin
        echo_out_true <= co_t;
        echo_out_inv  <= co_i;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/bsc_scan_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defs.vh"
// ----
// checks on the test port state machine and echo clocks
// ----
module bsc_scan_monitor (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       clk_in_true,
  input wire logic       clk_in_inv,
  input wire logic       clk_out_true,
  input wire logic       clk_out_inv,
  input wire logic       scan_out_oe,
  input wire logic       outputs_float,
  input wire logic       echo_out_true,
  input wire logic       echo_out_inv,
  input wire logic [2:0] instr,
  input wire logic [3:0] tap_state
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // echo tracking is suspended only under extest and float
  wire nf = instr != `BSC_IR_EXTEST && instr != `BSC_IR_SAMPZ;
  chk_tlr_id: assert property (tap_state == `BSC_S_TLR |-> ##[0:1] instr == `BSC_IR_IDCODE)
    else $error("reset state without identification");
  chk_tlr_exit: assert property ($past(tap_state) == `BSC_S_TLR && tap_state != `BSC_S_TLR
    |-> tap_state == `BSC_S_RTI) else $error("bad exit from reset state");
  chk_rti_exit: assert property ($past(tap_state) == `BSC_S_RTI && tap_state != `BSC_S_RTI
    |-> tap_state == `BSC_S_SDR) else $error("bad exit from idle");
  chk_cdr_exit: assert property ($past(tap_state) == `BSC_S_CDR && tap_state != `BSC_S_CDR
    |-> tap_state inside {`BSC_S_SHDR, `BSC_S_E1DR}) else $error("bad exit from capture");
  chk_oe_shift: assert property ($rose(scan_out_oe) |-> tap_state inside {`BSC_S_SHDR,
    `BSC_S_SHIR} || $past(tap_state) inside {`BSC_S_SHDR, `BSC_S_SHIR}) else $error("oe outside shift");
  chk_float_on: assert property (instr == `BSC_IR_SAMPZ |-> ##[0:2] outputs_float)
    else $error("outputs not floated");
  chk_echo_out: assert property ((nf && !(clk_out_true && clk_out_inv)
    && $stable({instr, clk_out_true, clk_out_inv}))[*8] |-> echo_out_true == clk_out_true
    && echo_out_inv == clk_out_inv) else $error("echo not following output clocks");
  chk_echo_in: assert property ((nf && clk_out_true && clk_out_inv
    && $stable({instr, clk_in_true, clk_in_inv}))[*8] |-> echo_out_true == clk_in_true
    && echo_out_inv == clk_in_inv) else $error("echo not following input clocks");
  cover property (outputs_float);
  cover property (instr == `BSC_IR_BYPASS && tap_state == `BSC_S_SHDR);
  cover property (tap_state == `BSC_S_SHIR);
endmodule
bind bsc_scan_chain bsc_scan_monitor i_bsc_scan_monitor (.clock, .rst, .clk_in_true, .clk_in_inv,
  .clk_out_true, .clk_out_inv, .scan_out_oe, .outputs_float, .echo_out_true, .echo_out_inv,
  .instr, .tap_state);
`default_nettype wire

/* File: verif/bsc_tap_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// board test controller; test clock idles low between frames
// ----
module bsc_tap_ctrl (
  input  wire logic clock,
  input  wire logic scan_out,
  output var  logic test_clk = 1'b0,
  output var  logic mode_sel = 1'b1,
  output var  logic scan_in = 1'b0
);
  // one 160 ns test clock; data out is read just before the rise
  task step(input logic tms, input logic tdi, output logic tdo);
    mode_sel = tms;
    scan_in = tdi;
    repeat (10) @(negedge clock);
    tdo = scan_out;
    test_clk = 1'b1;
    repeat (10) @(negedge clock);
    test_clk = 1'b0;
  endtask
  // idle -> shift-ir, three bits lsb first, update, back to idle
  task load_ir(input logic [2:0] code);
    logic d;
    step(1'b0, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < 3; i++)
      step(i == 2, code[i], d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
  // idle -> capture -> shift n cells, cell 1 comes out first
  task shift_dr(input int n, input logic [109:1] din, output logic [109:1] dout);
    logic d;
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 1; i <= n; i++)
      step(i == n, din[i], dout[i]);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule
`default_nettype wire

/* File: verif/bsc_scan_chain_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defs.vh"
// ----
// scan chain bench
// ----
module bsc_scan_chain_tb_top;
  logic         clock, rst, test_clk, mode_sel, scan_in, scan_out, outputs_float;
  logic         clk_in_true, clk_in_inv, clk_out_true, clk_out_inv, echo_out_true, echo_out_inv;
  logic [108:1] ball_in, ball_drive;
  logic         scan_out_oe, ball_drive_en;
  logic [2:0]   instr;
  logic [3:0]   tap_state;
  logic [109:1] dout;
  int           num_errors, comparisons, cycles;
  bsc_scan_chain i_bsc_scan_chain (.clock, .rst, .test_clk, .mode_sel, .scan_in, .ball_in,
    .clk_in_true, .clk_in_inv, .clk_out_true, .clk_out_inv, .scan_out, .scan_out_oe,
    .ball_drive, .ball_drive_en, .outputs_float, .echo_out_true, .echo_out_inv,
    .instr, .tap_state);
  bsc_tap_ctrl i_bsc_tap_ctrl (.clock, .scan_out, .test_clk, .mode_sel, .scan_in);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard; the run needs about 7000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results;
    end
  end
  task check(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // float mode: captured balls come out in cell order, internal cell last
  task test_float;
    ball_in = {9{12'h5c3}};
    i_bsc_tap_ctrl.load_ir(`BSC_IR_SAMPZ);
    check("float", 1'b1, outputs_float);
    i_bsc_tap_ctrl.shift_dr(109, '0, dout);
    check("cells", ball_in, dout[108:1]);
    check("cell 109", 1'b1, dout[109]);
    $display("test_float done");
  endtask
  // bypass delays by one cell; echo clocks follow the live clock pairs
  task test_bypass;
    i_bsc_tap_ctrl.load_ir(`BSC_IR_BYPASS);
    i_bsc_tap_ctrl.shift_dr(4, 109'h0b, dout);
    check("bypass", 4'b0110, dout[4:1]);
    clk_out_true = 1'b1;
    clk_out_inv = 1'b0;
    repeat (10) @(negedge clock);
    check("echo out", 2'b10, {echo_out_true, echo_out_inv});
    clk_out_inv = 1'b1;
    repeat (10) @(negedge clock);
    check("echo in", 2'b01, {echo_out_true, echo_out_inv});
    $display("test_bypass done");
  endtask
  // five high mode-select edges from mid-shift force the reset state
  task test_tlr;
    i_bsc_tap_ctrl.step(1'b1, 1'b0, dout[1]);
    i_bsc_tap_ctrl.step(1'b0, 1'b0, dout[1]);
    i_bsc_tap_ctrl.step(1'b0, 1'b0, dout[1]);
    repeat (5) i_bsc_tap_ctrl.step(1'b1, 1'b0, dout[1]);
    check("state", `BSC_S_TLR, tap_state);
    check("instr", `BSC_IR_IDCODE, instr);
    $display("test_tlr done");
  endtask
  // sample captures the balls and preloads a pattern that extest then drives
  task test_extest;
    ball_in = {9{12'h3e1}};
    i_bsc_tap_ctrl.load_ir(`BSC_IR_SAMPLE);
    check("float off", 1'b0, outputs_float);
    i_bsc_tap_ctrl.shift_dr(109, {1'b0, {9{12'ha96}}}, dout);
    check("sampled cells", ball_in, dout[108:1]);
    check("sampled cell 109", 1'b1, dout[109]);
    check("oe idle", 1'b0, scan_out_oe);
    i_bsc_tap_ctrl.load_ir(`BSC_IR_EXTEST);
    check("drive en", 1'b1, ball_drive_en);
    check("drive", {9{12'ha96}}, ball_drive);
    clk_out_inv = 1'b0;
    repeat (10) @(negedge clock);
    check("echo held", 2'b01, {echo_out_true, echo_out_inv});
    $display("test_extest done");
  endtask
  // identification word comes out lsb first; echo follows output clocks again
  task test_idcode;
    i_bsc_tap_ctrl.load_ir(`BSC_IR_IDCODE);
    i_bsc_tap_ctrl.shift_dr(32, '0, dout);
    check("id", `BSC_ID_VALUE, dout[32:1]);
    check("echo back", 2'b10, {echo_out_true, echo_out_inv});
    $display("test_idcode done");
  endtask
  initial begin
    rst = 1'b1;
    ball_in = '0;
    clk_in_true = 1'b0;
    clk_in_inv = 1'b1;
    clk_out_true = 1'b0;
    clk_out_inv = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    check("reset instr", `BSC_IR_IDCODE, instr);
    test_float;
    test_bypass;
    test_tlr;
    test_extest;
    test_idcode;
    results;
  end
endmodule
`default_nettype wire
